// ---- rtl/cfr_map.vh ----
`ifndef CFR_MAP_VH
`define CFR_MAP_VH
// Instruction codes, ten bits each
`define CFR_OP_CLEAR_CARRY 10'h006
`define CFR_OP_SET_CARRY 10'h007
`define CFR_OP_PORT_CLEAR 10'h014
`define CFR_OP_SUB_RETURN 10'h044
`define CFR_OP_INT_RETURN 10'h046
`define CFR_OP_RETURN_SKIP 10'h043
`define CFR_OP_CLEAR_HIGH_REF 10'h058
`define CFR_OP_BIT_SET_BASE 10'h05c
// Field positions
`define CFR_BIT_SEL_LSB 0
`define CFR_BIT_SEL_MSB 1
// Cycle counts
`define CFR_RET_CYCLES 2'h2
// Reset values
`define CFR_CARRY_RST 1'h0
`define CFR_HIGH_REF_RST 1'h0
`define CFR_PORT_RST 6'h3f
`endif

// ---- rtl/cfr_core.v ----
`timescale 1ns/100ps
`include "cfr_map.vh"
module cfr_core #(
    parameter PC_W = 11, // Program counter width
    parameter SP_W = 3, // Stack index width
    parameter DP_W = 10, // Data pointer width (X,Y,Z packed)
    parameter AUX_W = 4 // Auxiliary register width
) (
    input wire i_clk,
    input wire i_srst,
    input wire i_ce,
    input wire i_valid, // Instruction word present
    input wire [9:0] i_instr, // Fetched instruction
    input wire [2:0] i_index, // Index register value
    input wire [DP_W-1:0] i_data_pointer, // Current data pointer
    input wire [3:0] i_mem_rdata, // Nibble at data pointer
    input wire [PC_W-1:0] i_return_stack_top, // Entry at stack index
    input wire [SP_W-1:0] i_stack_index, // Current stack index
    input wire [DP_W-1:0] i_saved_dp, // Pointer saved at interrupt entry
    input wire i_saved_skip_mode, // Skip suppression saved at entry
    input wire [AUX_W-1:0] i_saved_aux, // Aux register saved at entry
    output reg o_carry_flag, // Carry flag
    output reg o_high_ref_enable_flag, // High-order reference enable
    output reg [5:0] o_port, // Output port bits
    output reg o_mem_we, // Memory write strobe
    output reg [DP_W-1:0] o_mem_addr, // Memory write address
    output reg [3:0] o_mem_wdata, // Memory write data
    output reg o_pc_load, // Load program counter strobe
    output reg [PC_W-1:0] o_pc, // New program counter
    output reg o_sp_load, // Load stack index strobe
    output reg [SP_W-1:0] o_stack_index, // New stack index
    output reg o_skip_next, // Skip the following instruction
    output reg o_restore, // Restore saved state strobe
    output reg [DP_W-1:0] o_data_pointer, // Restored pointer
    output reg o_skip_mode, // Restored skip suppression
    output reg [AUX_W-1:0] o_aux, // Restored aux register
    output reg o_busy // Second cycle of a return
);

    // Operation overview
    //
    // One word is taken per enabled edge
    // Taken only with valid high and not busy
    // Answer appears on the following edge
    // Strobes stand for one cycle only
    // Flags and port bits hold until changed
    //
    // Clock enable
    // Low enable freezes every register unless reset is high
    // Strobes also hold while frozen
    // Sequencer does not advance while frozen
    //
    // Reset
    // Synchronous, active high
    // Carry and high-ref flags cleared
    // Port bits return to all ones
    // Strobes and buses cleared
    // Sequencer back to idle
    //
    // Carry handling
    // Only the two carry ops write carry
    // Every other word leaves carry alone
    //
    // Port-bit clear
    // Index register picks the port bit
    // Indexes six and seven do nothing
    // Software must avoid those indexes
    //
    // Subroutine return and return-and-skip
    // Program counter loaded from stack top
    // Stack index decremented, wraps at zero
    // Second cycle held busy, word dropped
    // Return-and-skip flags skip in cycle two
    // Skip pulse follows the load pulse
    //
    // Interrupt return
    // Single cycle, no busy cycle
    // Counter and stack index as for return
    // Saved pointer, skip mode, aux restored
    // Restore strobe marks the restored values
    //
    // High-ref flag clear
    // Clears the reference enable flag only
    //
    // Memory bit set
    // Low two opcode bits pick the bit
    // Nibble read at pointer, bit forced high
    // Write strobe with address and data
    // Address and data hold until next write
    //
    // Unknown words
    // Any other code is a no-op here
    // Neighbouring slices decode the rest
    //
    // Hazard
    // Stack top must be valid with the word
    // Saved state must be valid with the word
    // No bypass from memory write to read

    // States, one-hot
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    reg [1:0] state_r; // Sequencer state
    reg skip_pend_r; // Return-and-skip in progress

    // Bit-set opcode match, low two bits are the bit index
    function is_bit_set;
        input [9:0] w;
        begin
            is_bit_set = ({w[9:2], 2'b00} == `CFR_OP_BIT_SET_BASE);
        end
    endfunction

    // Nibble with one bit forced high
    function [3:0] set_nibble_bit;
        input [3:0] d;
        input [1:0] j;
        begin
            set_nibble_bit = d | (4'h1 << j);
        end
    endfunction

    // Decode and execute
    always @(posedge i_clk) begin
        if (i_srst) begin
            state_r <= ST_IDLE;
            skip_pend_r <= 1'b0;
            o_carry_flag <= `CFR_CARRY_RST;
            o_high_ref_enable_flag <= `CFR_HIGH_REF_RST;
            o_port <= `CFR_PORT_RST;
            o_mem_we <= 1'b0;
            o_mem_addr <= {DP_W{1'b0}};
            o_mem_wdata <= 4'h0;
            o_pc_load <= 1'b0;
            o_pc <= {PC_W{1'b0}};
            o_sp_load <= 1'b0;
            o_stack_index <= {SP_W{1'b0}};
            o_skip_next <= 1'b0;
            o_restore <= 1'b0;
            o_data_pointer <= {DP_W{1'b0}};
            o_skip_mode <= 1'b0;
            o_aux <= {AUX_W{1'b0}};
            o_busy <= 1'b0;
        end else if (i_ce) begin
            // Strobes default low
            o_mem_we <= 1'b0;
            o_pc_load <= 1'b0;
            o_sp_load <= 1'b0;
            o_skip_next <= 1'b0;
            o_restore <= 1'b0;
            case (state_r)
                ST_WAIT: begin
                    // Second cycle of a two-cycle return
                    state_r <= ST_IDLE;
                    o_busy <= 1'b0;
                    o_skip_next <= skip_pend_r;
                    skip_pend_r <= 1'b0;
                end
                default: begin
                    state_r <= ST_IDLE;
                    if (i_valid) begin
                        // Carry only touched by its own ops
                        if (i_instr == `CFR_OP_CLEAR_CARRY) begin
                            o_carry_flag <= 1'b0;
                        end else if (i_instr == `CFR_OP_SET_CARRY) begin
                            o_carry_flag <= 1'b1;
                        end else if (i_instr == `CFR_OP_PORT_CLEAR) begin
                            // Out-of-range index ignored
                            if (i_index <= 3'h5) begin
                                o_port[i_index] <= 1'b0;
                            end
                        end else if (i_instr == `CFR_OP_SUB_RETURN ||
                                     i_instr == `CFR_OP_RETURN_SKIP) begin
                            // Pop, then hold a second cycle
                            o_pc_load <= 1'b1;
                            o_pc <= i_return_stack_top;
                            o_sp_load <= 1'b1;
                            o_stack_index <= i_stack_index - 1'b1;
                            o_busy <= 1'b1;
                            state_r <= ST_WAIT;
                            skip_pend_r <=
                                (i_instr == `CFR_OP_RETURN_SKIP);
                        end else if (i_instr == `CFR_OP_INT_RETURN) begin
                            // Single-cycle pop with restore
                            o_pc_load <= 1'b1;
                            o_pc <= i_return_stack_top;
                            o_sp_load <= 1'b1;
                            o_stack_index <= i_stack_index - 1'b1;
                            o_restore <= 1'b1;
                            o_data_pointer <= i_saved_dp;
                            o_skip_mode <= i_saved_skip_mode;
                            o_aux <= i_saved_aux;
                        end else if (i_instr ==
                                     `CFR_OP_CLEAR_HIGH_REF) begin
                            o_high_ref_enable_flag <= 1'b0;
                        end else if (is_bit_set(i_instr)) begin
                            // Read-modify-write of the nibble
                            o_mem_we <= 1'b1;
                            o_mem_addr <= i_data_pointer;
                            o_mem_wdata <= set_nibble_bit(i_mem_rdata,
                                i_instr[`CFR_BIT_SEL_MSB:`CFR_BIT_SEL_LSB]);
                        end
                    end
                end
            endcase
        end
    end

endmodule // cfr_core

// ---- testbench/cfr_core_assertions.sv ----
`timescale 1ns/100ps
// Ties each accepted word to the state change it must cause
module cfr_core_assertions #(parameter PC_W = 11, parameter SP_W = 3) (
    input wire i_clk, input wire i_srst, input wire i_ce,
    input wire i_valid, input wire [9:0] i_instr, input wire [2:0] i_index,
    input wire [3:0] i_mem_rdata, input wire [PC_W-1:0] i_return_stack_top,
    input wire [SP_W-1:0] i_stack_index, input wire o_carry_flag,
    input wire o_high_ref_enable_flag, input wire [5:0] o_port,
    input wire o_mem_we, input wire [3:0] o_mem_wdata, input wire o_pc_load,
    input wire [PC_W-1:0] o_pc, input wire [SP_W-1:0] o_stack_index,
    input wire o_skip_next, input wire o_restore, input wire o_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire tk = i_ce && i_valid && !o_busy; // Word accepted this edge
    property p_rc; tk && i_instr == 10'h006 |=> !o_carry_flag; endproperty
    a_rc: assert property (p_rc) else $error("carry kept");
    property p_sc; tk && i_instr == 10'h007 |=> o_carry_flag; endproperty
    a_sc: assert property (p_sc) else $error("carry clear");
    property p_pt; tk && i_instr == 10'h014 && i_index < 3'h6
        |=> !o_port[$past(i_index)]; endproperty
    a_pt: assert property (p_pt) else $error("port bit high");
    property p_rt; tk && i_instr == 10'h044 |=> o_pc_load && o_busy
        && o_pc == $past(i_return_stack_top)
        && o_stack_index == $past(i_stack_index) - 1'b1 ##1 !o_busy;
    endproperty
    a_rt: assert property (p_rt) else $error("bad return");
    property p_ri; tk && i_instr == 10'h046
        |=> o_pc_load && o_restore && !o_busy; endproperty
    a_ri: assert property (p_ri) else $error("bad rti");
    property p_rs; tk && i_instr == 10'h043 |=> o_pc_load ##1 o_skip_next;
    endproperty
    a_rs: assert property (p_rs) else $error("no skip");
    property p_sb; tk && i_instr[9:2] == 8'h17 |=> o_mem_we && o_mem_wdata
        == ($past(i_mem_rdata) | 4'h1 << $past(i_instr[1:0])); endproperty
    a_sb: assert property (p_sb) else $error("bad bit set");
    property p_ur; tk && i_instr == 10'h058
        |=> !o_high_ref_enable_flag && $stable(o_carry_flag); endproperty
    a_ur: assert property (p_ur) else $error("bad flag");
endmodule // cfr_core_assertions
bind cfr_core cfr_core_assertions #(.PC_W(PC_W), .SP_W(SP_W))
    cfr_core_assertions_i (.*);

// ---- testbench/cfr_core_flag_return_bit_ops_bench.sv ----
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
    n_errors++; $display("wrong value %s exp %h got %h", n, e, s); end end
module cpu_flag_return_bit_ops_bench;
    reg i_clk = 0, i_srst = 1, i_ce = 1, i_valid = 0, i_saved_skip_mode = 1;
    reg [9:0] i_instr = 10'h000, i_data_pointer = 10'h2a5;
    reg [9:0] i_saved_dp = 10'h15a; // Pointer at interrupt entry
    reg [2:0] i_index = 3'h0, i_stack_index = 3'h0; // Zero tests wrap
    reg [3:0] i_mem_rdata = 4'h2, i_saved_aux = 4'h9;
    reg [10:0] i_return_stack_top = 11'h5b3;
    wire o_carry_flag, o_high_ref_enable_flag, o_mem_we, o_pc_load, o_sp_load;
    wire o_skip_next, o_restore, o_skip_mode, o_busy;
    wire [5:0] o_port;
    wire [3:0] o_mem_wdata, o_aux;
    wire [9:0] o_mem_addr, o_data_pointer;
    wire [10:0] o_pc;
    wire [2:0] o_stack_index;
    int n_errors = 0, total_checks = 0, k;
    cfr_core cfr_core_i (.*);
    // Offer one word at a falling edge, taken at the next rise
    task op(input [9:0] w);
        i_instr = w;
        i_valid = 1;
        @(negedge i_clk);
    endtask
    task t_ce; // Frozen enable, then a mid-run reset
        i_ce = 0;
        op(10'h007); `CHK("cy", 1'b0, o_carry_flag)
        i_ce = 1;
        i_valid = 0;
        i_srst = 1;
        @(negedge i_clk); `CHK("port", 6'h3f, o_port)
        `CHK("cy", 1'b0, o_carry_flag)
        i_srst = 0;
        @(negedge i_clk); `CHK("busy", 1'b0, o_busy)
    endtask
    task t_carry; // Flag ops back to back
        op(10'h007); `CHK("cy", 1'b1, o_carry_flag)
        op(10'h058); `CHK("cy", 1'b1, o_carry_flag)
        `CHK("ref", 1'b0, o_high_ref_enable_flag)
        op(10'h006); `CHK("cy", 1'b0, o_carry_flag)
    endtask
    task t_port; // Every legal index, then an illegal one
        for (k = 0; k < 7; k++) begin
            i_index = k[2:0];
            op(10'h014);
            `CHK("port", 6'h3f << (k < 6 ? k + 1 : 6), o_port)
        end
    endtask
    task t_ret; // Pop with wrap; a word offered while busy is dropped
        op(10'h044); `CHK("pc", 11'h5b3, o_pc)
        `CHK("sp", 3'h7, o_stack_index)
        `CHK("spld", 1'b1, o_sp_load)
        op(10'h007); `CHK("cy", 1'b0, o_carry_flag)
        `CHK("busy", 1'b0, o_busy)
        op(10'h043); `CHK("ld", 1'b1, o_pc_load)
        @(negedge i_clk); `CHK("skip", 1'b1, o_skip_next)
    endtask
    task t_rti; // Restore of saved state in one cycle
        op(10'h046); `CHK("busy", 1'b0, o_busy)
        `CHK("ld", 1'b1, o_pc_load)
        `CHK("rst", 1'b1, o_restore)
        `CHK("dp", 10'h15a, o_data_pointer)
        `CHK("aux", 4'h9, o_aux)
        `CHK("skm", 1'b1, o_skip_mode)
    endtask
    task t_sb; // Each bit position over a set pattern
        for (k = 0; k < 4; k++) begin
            op(10'h05c + k[9:0]);
            `CHK("wd", 4'h2 | 4'h1 << k, o_mem_wdata)
            `CHK("wa", 10'h2a5, o_mem_addr)
            `CHK("we", 1'b1, o_mem_we)
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial forever #25 i_clk = ~i_clk;
    // Run needs some thirty cycles; cut off well past that
    initial begin
        #100000;
        n_errors++;
        finish_test;
    end
    initial begin
        repeat (8) @(negedge i_clk);
        i_srst = 0;
        `CHK("port", 6'h3f, o_port)
        t_carry;
        t_port;
        t_ret;
        t_rti;
        t_sb;
        t_ce;
        finish_test;
    end
endmodule // cpu_flag_return_bit_ops_bench
